// ==== design/twsp_pkg.sv ====
// Shared constants and types for the two-wire slave port and its master.
// Assumes a single system clock at CLK_HZ on both ends.
package twsp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and line rates
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned SCL_STD_HZ = 100_000;
  localparam int unsigned SCL_FAST_HZ = 400_000;

  ////////////////////////////////////////////////////////////////////////////
  // Addressing
  localparam logic [7:0] AUX_ADDR = 8'hA0;
  localparam logic [7:0] MAIN_ADDR_DFLT = 8'hA2;
  // Arbitrary value
  localparam logic [3:0] TYPE_CODE_DFLT = 4'h6;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////
  // Bit framing and filtering
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int unsigned FILT_LEN_DFLT = 3;

  ////////////////////////////////////////////////////////////////////////////
  // State and command encodings
  typedef enum logic [2:0] {
    DS_IDLE = 3'b000,
    DS_ADDR = 3'b001,
    DS_ADDR_ACK = 3'b010,
    DS_WR = 3'b011,
    DS_WR_ACK = 3'b100,
    DS_RD = 3'b101,
    DS_RD_ACK = 3'b110
  } twsp_dstate_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_START = 2'b01,
    HS_STOP = 2'b10,
    HS_BYTE = 2'b11
  } twsp_hstate_t;

  typedef enum logic [1:0] {
    CMD_START = 2'b00,
    CMD_STOP = 2'b01,
    CMD_WRITE = 2'b10,
    CMD_READ = 2'b11
  } twsp_cmd_t;

endpackage

// ==== design/twsp_if.sv ====
// Two-wire bus between master and slave port.
// Assumes open-drain lines with pull-ups; enables are active low.
`timescale 1ns/1ps
interface twsp_if;
  logic scl;
  logic sda;
  logic m_scl_out;
  logic m_scl_oe_n;
  logic m_sda_out;
  logic m_sda_oe_n;
  logic s_sda_out;
  logic s_sda_oe_n;

  // Wired-and with pull-up
  assign scl = m_scl_oe_n ? 1'b1 : m_scl_out;
  assign sda = (m_sda_oe_n ? 1'b1 : m_sda_out) &
               (s_sda_oe_n ? 1'b1 : s_sda_out);

  modport dev (input scl, input sda, output s_sda_out, output s_sda_oe_n);
  modport host (input scl, input sda, output m_scl_out, output m_scl_oe_n,
                output m_sda_out, output m_sda_oe_n);
endinterface

// ==== design/twsp_dev.sv ====
// Two-wire slave port: device end with receive buffer and transmit feed.
// Assumes the master owns the clock line and never stretches it.
//
// Functional notes
// - Master starts only while bus idle
// - Data steady while clock high
// - Data fall, clock high: start
// - Data rise, clock high: stop
// - One clock per bit, change when low
// - Bytes MSB first, ninth bit acknowledge
// - Any byte count between start, stop
// - Works at 100 kHz and 400 kHz
// - Master adds ninth clock pulse
// - Acknowledge holds data low through clock high
// - Master leaves final read byte unacknowledged
// - Release data after master withholds acknowledge
// - Write: control byte then acked data bytes; port withholds ack and drops the byte while both receive entries are full
// - Stop or repeated start ends transfer
// - Read selected: port drives data line
// - Match only after address and direction
// - Upper nibble must equal type code
// - Address matches auxiliary or main address
// - Direction bit one reads, zero writes
// - Acknowledge matching control byte
// - Main and auxiliary select own block
// - Mismatch: no acknowledge, idle until start
`timescale 1ns/1ps
module twsp_dev #(
  parameter logic [3:0] TYPE_CODE = twsp_pkg::TYPE_CODE_DFLT,
  parameter int unsigned FILT_LEN = twsp_pkg::FILT_LEN_DFLT
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Bus
  twsp_if.dev bus,
  // Configuration
  input wire logic [7:0] main_addr_in,
  // Received bytes
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  input wire logic rx_ready_in,
  // Bytes to send
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  // Transfer status
  output logic sel_main_out,
  output logic sel_aux_out,
  output logic rd_mode_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and glitch filters
  logic [1:0] line_raw;
  logic [1:0] line_f;
  logic scl_f;
  logic sda_f;
  logic scl_p_ff;
  logic sda_p_ff;

  assign line_raw = {bus.scl, bus.sda};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_line
      logic sync1_ff;
      logic sync2_ff;
      logic [FILT_LEN-1:0] hist_ff;
      logic filt_ff;
      always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
          sync1_ff <= 1'b1;
          sync2_ff <= 1'b1;
          hist_ff <= '1;
          filt_ff <= 1'b1;
        end else begin
          sync1_ff <= line_raw[gi];
          sync2_ff <= sync1_ff;
          hist_ff <= {hist_ff[FILT_LEN-2:0], sync2_ff};
          if (&hist_ff) begin
            filt_ff <= 1'b1;
          end else if (~|hist_ff) begin
            filt_ff <= 1'b0;
          end
        end
      end
      assign line_f[gi] = filt_ff;
    end
  endgenerate

  assign scl_f = line_f[1];
  assign sda_f = line_f[0];

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_p_ff <= 1'b1;
      sda_p_ff <= 1'b1;
    end else begin
      scl_p_ff <= scl_f;
      sda_p_ff <= sda_f;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus events
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise = scl_f & ~scl_p_ff;
  assign scl_fall = ~scl_f & scl_p_ff;
  assign start_det = scl_f & scl_p_ff & sda_p_ff & ~sda_f;
  assign stop_det = scl_f & scl_p_ff & ~sda_p_ff & sda_f;

  ////////////////////////////////////////////////////////////////////////////
  // Protocol engine
  twsp_pkg::twsp_dstate_t state_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] rx_sh_ff;
  logic [7:0] tx_sh_ff;
  logic sda_oe_n_ff;
  logic sda_out_ff;
  logic acked_ff;
  logic tail_vld_ff;
  logic type_hit;
  logic aux_hit;
  logic main_hit;
  logic byte_done;
  logic push;
  logic tx_load;
  logic [7:0] tx_byte;

  assign byte_done = scl_fall && (bit_cnt_ff == twsp_pkg::BYTE_BITS);
  assign type_hit = rx_sh_ff[7:4] == TYPE_CODE;
  assign aux_hit = type_hit &&
                   (rx_sh_ff[3:1] == twsp_pkg::AUX_ADDR[3:1]);
  assign main_hit = type_hit && (rx_sh_ff[3:1] == main_addr_in[3:1]);
  assign push = (state_ff == twsp_pkg::DS_WR) && byte_done &&
                !tail_vld_ff;
  assign tx_byte = tx_valid_in ? tx_data_in : twsp_pkg::IDLE_BYTE;
  assign tx_load = scl_fall &&
                   (((state_ff == twsp_pkg::DS_ADDR_ACK) && rd_mode_out) ||
                    ((state_ff == twsp_pkg::DS_RD_ACK) && acked_ff));

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_ff <= twsp_pkg::DS_IDLE;
      bit_cnt_ff <= 4'h0;
      rx_sh_ff <= 8'h00;
      tx_sh_ff <= 8'hFF;
      sda_oe_n_ff <= 1'b1;
      acked_ff <= 1'b0;
      sel_main_out <= 1'b0;
      sel_aux_out <= 1'b0;
      rd_mode_out <= 1'b0;
    end else if (stop_det) begin
      state_ff <= twsp_pkg::DS_IDLE;
      sda_oe_n_ff <= 1'b1;
      sel_main_out <= 1'b0;
      sel_aux_out <= 1'b0;
    end else if (start_det) begin
      state_ff <= twsp_pkg::DS_ADDR;
      bit_cnt_ff <= 4'h0;
      sda_oe_n_ff <= 1'b1;
      sel_main_out <= 1'b0;
      sel_aux_out <= 1'b0;
    end else begin
      case (state_ff)
        twsp_pkg::DS_ADDR, twsp_pkg::DS_WR: begin
          if (scl_rise) begin
            rx_sh_ff <= {rx_sh_ff[6:0], sda_f};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end else if (byte_done) begin
            bit_cnt_ff <= 4'h0;
            if (state_ff == twsp_pkg::DS_WR) begin
              state_ff <= twsp_pkg::DS_WR_ACK;
              sda_oe_n_ff <= tail_vld_ff;
            end else if (aux_hit || main_hit) begin
              state_ff <= twsp_pkg::DS_ADDR_ACK;
              sda_oe_n_ff <= 1'b0;
              sel_aux_out <= aux_hit;
              sel_main_out <= main_hit && !aux_hit;
              rd_mode_out <= rx_sh_ff[0];
            end else begin
              state_ff <= twsp_pkg::DS_IDLE;
            end
          end
        end
        twsp_pkg::DS_ADDR_ACK, twsp_pkg::DS_WR_ACK: begin
          if (tx_load) begin
            state_ff <= twsp_pkg::DS_RD;
            tx_sh_ff <= tx_byte;
            sda_oe_n_ff <= tx_byte[7];
            bit_cnt_ff <= 4'h1;
          end else if (scl_fall) begin
            state_ff <= twsp_pkg::DS_WR;
            sda_oe_n_ff <= 1'b1;
          end
        end
        twsp_pkg::DS_RD: begin
          if (byte_done) begin
            state_ff <= twsp_pkg::DS_RD_ACK;
            sda_oe_n_ff <= 1'b1;
          end else if (scl_fall) begin
            sda_oe_n_ff <= tx_sh_ff[6];
            tx_sh_ff <= {tx_sh_ff[6:0], 1'b1};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
        end
        twsp_pkg::DS_RD_ACK: begin
          if (scl_rise) begin
            acked_ff <= ~sda_f;
          end else if (tx_load) begin
            state_ff <= twsp_pkg::DS_RD;
            tx_sh_ff <= tx_byte;
            sda_oe_n_ff <= tx_byte[7];
            bit_cnt_ff <= 4'h1;
          end else if (scl_fall) begin
            state_ff <= twsp_pkg::DS_IDLE;
            sda_oe_n_ff <= 1'b1;
          end
        end
        twsp_pkg::DS_IDLE: begin
          sda_oe_n_ff <= 1'b1;
        end
        default: begin
          state_ff <= twsp_pkg::DS_IDLE;
          sda_oe_n_ff <= 1'b1;
        end
      endcase
    end
  end

  // Open drain: only ever pulls low
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sda_out_ff <= 1'b0;
    end else begin
      sda_out_ff <= 1'b0;
    end
  end

  assign bus.s_sda_oe_n = sda_oe_n_ff;
  assign bus.s_sda_out = sda_out_ff;

  // Transmit byte taken
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_ready_out <= 1'b0;
    end else begin
      tx_ready_out <= tx_load && tx_valid_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry receive buffer
  logic [7:0] tail_ff;
  logic pop;

  assign pop = rx_valid_out && rx_ready_in;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_data_out <= 8'h00;
      rx_valid_out <= 1'b0;
      tail_ff <= 8'h00;
      tail_vld_ff <= 1'b0;
    end else if (pop) begin
      if (tail_vld_ff) begin
        rx_data_out <= tail_ff;
        tail_vld_ff <= push;
        if (push) begin
          tail_ff <= rx_sh_ff;
        end
      end else begin
        rx_valid_out <= push;
        if (push) begin
          rx_data_out <= rx_sh_ff;
        end
      end
    end else if (push) begin
      if (!rx_valid_out) begin
        rx_data_out <= rx_sh_ff;
        rx_valid_out <= 1'b1;
      end else begin
        tail_ff <= rx_sh_ff;
        tail_vld_ff <= 1'b1;
      end
    end
  end

endmodule

// ==== design/twsp_host.sv ====
// Two-wire bus master: makes the clock, conditions and byte transfers.
// Assumes one command at a time from user logic on the same clock.
`timescale 1ns/1ps
module twsp_host #(
  parameter int unsigned SCL_HZ = twsp_pkg::SCL_STD_HZ
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Bus
  twsp_if.host bus,
  // Command
  input wire logic cmd_valid_in,
  input wire logic [1:0] cmd_in,
  input wire logic [7:0] cmd_data_in,
  input wire logic cmd_nack_in,
  output logic cmd_ready_out,
  // Response
  output logic rsp_valid_out,
  output logic [7:0] rsp_data_out,
  output logic rsp_ack_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Quarter-bit tick
  localparam int unsigned QTR_CYC = twsp_pkg::CLK_HZ / (4 * SCL_HZ);
  localparam logic [15:0] QTR_MAX = 16'(QTR_CYC - 1);
  logic [15:0] div_ff;
  logic tick;

  assign tick = div_ff == QTR_MAX;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_ff <= 16'h0000;
    end else begin
      div_ff <= tick ? 16'h0000 : div_ff + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line synchronisers
  logic [1:0] s1_ff;
  logic [1:0] s2_ff;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s1_ff <= 2'b11;
      s2_ff <= 2'b11;
    end else begin
      s1_ff <= {bus.scl, bus.sda};
      s2_ff <= s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  twsp_pkg::twsp_hstate_t state_ff;
  logic [1:0] phase_ff;
  logic [3:0] bit_ff;
  logic [1:0] cmd_ff;
  logic [7:0] tx_ff;
  logic nack_ff;
  logic scl_oe_n_ff;
  logic sda_oe_n_ff;
  logic last_ph;

  assign last_ph = tick && (phase_ff == 2'b11);

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_ff <= twsp_pkg::HS_IDLE;
      phase_ff <= 2'b00;
      bit_ff <= 4'h0;
      cmd_ff <= 2'b00;
      tx_ff <= 8'h00;
      nack_ff <= 1'b0;
      scl_oe_n_ff <= 1'b1;
      sda_oe_n_ff <= 1'b1;
      cmd_ready_out <= 1'b1;
      rsp_valid_out <= 1'b0;
      rsp_data_out <= 8'h00;
      rsp_ack_out <= 1'b0;
    end else begin
      rsp_valid_out <= 1'b0;
      case (state_ff)
        twsp_pkg::HS_IDLE: begin
          if (cmd_valid_in && cmd_ready_out) begin
            cmd_ready_out <= 1'b0;
            cmd_ff <= cmd_in;
            tx_ff <= cmd_data_in;
            nack_ff <= cmd_nack_in;
            phase_ff <= 2'b00;
            bit_ff <= 4'h0;
            case (cmd_in)
              twsp_pkg::CMD_START: state_ff <= twsp_pkg::HS_START;
              twsp_pkg::CMD_STOP: state_ff <= twsp_pkg::HS_STOP;
              default: state_ff <= twsp_pkg::HS_BYTE;
            endcase
          end
        end
        twsp_pkg::HS_START: begin
          if (tick) begin
            case (phase_ff)
              2'b00: sda_oe_n_ff <= 1'b1;
              2'b01: scl_oe_n_ff <= 1'b1;
              // Hold until both lines read high
              2'b10: sda_oe_n_ff <= !(s2_ff == 2'b11);
              default: scl_oe_n_ff <= 1'b0;
            endcase
            if (phase_ff != 2'b10 || s2_ff == 2'b11) begin
              phase_ff <= phase_ff + 2'b01;
            end
          end
        end
        twsp_pkg::HS_STOP: begin
          if (tick) begin
            case (phase_ff)
              2'b00: sda_oe_n_ff <= 1'b0;
              2'b01: scl_oe_n_ff <= 1'b1;
              2'b10: sda_oe_n_ff <= 1'b1;
              default: sda_oe_n_ff <= 1'b1;
            endcase
            phase_ff <= phase_ff + 2'b01;
          end
        end
        twsp_pkg::HS_BYTE: begin
          if (tick) begin
            case (phase_ff)
              2'b00: begin
                if (bit_ff == twsp_pkg::BYTE_BITS) begin
                  // Ack clock; drive ack when reading
                  sda_oe_n_ff <= (cmd_ff == twsp_pkg::CMD_WRITE) || nack_ff;
                end else begin
                  sda_oe_n_ff <= (cmd_ff == twsp_pkg::CMD_READ) || tx_ff[7];
                end
              end
              2'b01: scl_oe_n_ff <= 1'b1;
              2'b10: begin
                if (bit_ff == twsp_pkg::BYTE_BITS) begin
                  rsp_ack_out <= ~s2_ff[0];
                end else begin
                  rsp_data_out <= {rsp_data_out[6:0], s2_ff[0]};
                  tx_ff <= {tx_ff[6:0], 1'b1};
                end
              end
              default: begin
                scl_oe_n_ff <= 1'b0;
                bit_ff <= bit_ff + 4'h1;
              end
            endcase
            phase_ff <= phase_ff + 2'b01;
          end
          if (last_ph && bit_ff == twsp_pkg::BYTE_BITS) begin
            sda_oe_n_ff <= 1'b1;
          end
        end
        default: state_ff <= twsp_pkg::HS_IDLE;
      endcase
      if (state_ff != twsp_pkg::HS_IDLE && last_ph &&
          (state_ff != twsp_pkg::HS_BYTE ||
           bit_ff == twsp_pkg::BYTE_BITS)) begin
        state_ff <= twsp_pkg::HS_IDLE;
        cmd_ready_out <= 1'b1;
        rsp_valid_out <= 1'b1;
      end
    end
  end

  assign bus.m_scl_out = 1'b0;
  assign bus.m_sda_out = 1'b0;
  assign bus.m_scl_oe_n = scl_oe_n_ff;
  assign bus.m_sda_oe_n = sda_oe_n_ff;

endmodule

// ==== test/twsp_checker.sv ====
// Concurrent checks on the two-wire lines between master and slave port.
// Assumes both lines are driven from flops on the same system clock.
`timescale 1ns/1ps
module twsp_checker (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // Bus lines and data enables
  input wire logic scl,
  input wire logic sda,
  input wire logic m_sda_oe_n,
  input wire logic s_sda_oe_n
);
  logic scl_q_ff, sda_q_ff, busy_ff, first_ff, dir_ff, nack_ff;
  logic [3:0] bit_ff;
  logic start_c, stop_c, fall_c, rise_c;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  ////////////////////////////////////////////////////////////////////////////
  // Line history and conditions
  assign start_c = scl & scl_q_ff & sda_q_ff & ~sda;
  assign stop_c = scl & scl_q_ff & ~sda_q_ff & sda;
  assign fall_c = scl_q_ff & ~scl;
  assign rise_c = ~scl_q_ff & scl;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl;
      sda_q_ff <= sda;
    end
  end

  // Frame and bit position
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_ff <= 1'b0;
      first_ff <= 1'b0;
      bit_ff <= 4'h0;
    end else if (start_c) begin
      busy_ff <= 1'b1;
      first_ff <= 1'b1;
      // Start's own clock fall wraps it to zero
      bit_ff <= 4'hF;
    end else if (stop_c) begin
      busy_ff <= 1'b0;
    end else if (fall_c) begin
      bit_ff <= (bit_ff == 4'h8) ? 4'h0 : bit_ff + 4'h1;
      if (bit_ff == 4'h8) begin
        first_ff <= 1'b0;
      end
    end
  end

  // Direction and master refusal
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dir_ff <= 1'b0;
      nack_ff <= 1'b0;
    end else if (start_c || stop_c) begin
      nack_ff <= 1'b0;
    end else if (rise_c && first_ff && bit_ff == 4'h7) begin
      dir_ff <= sda;
    end else if (rise_c && !first_ff && dir_ff && bit_ff == 4'h8 && sda) begin
      nack_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  chk_data_steady:
  assert property (scl && scl_q_ff |-> $stable(s_sda_oe_n))
    else $error("slave data moved while clock high");
  chk_ack_low:
  assert property (rise_c && bit_ff == 4'h8 && !s_sda_oe_n |-> !sda [*8])
    else $error("acknowledge not held low");
  chk_ctrl_quiet:
  assert property (busy_ff && first_ff && bit_ff < 4'h8 |-> s_sda_oe_n)
    else $error("slave drove during control byte");
  chk_wr_quiet:
  assert property (busy_ff && !first_ff && !dir_ff && scl && bit_ff < 4'h8
    |-> s_sda_oe_n)
    else $error("slave drove during write data");
  chk_rd_host_quiet:
  assert property (busy_ff && !first_ff && dir_ff && !nack_ff && scl
    && bit_ff < 4'h8 |-> m_sda_oe_n)
    else $error("master drove during read data");
  chk_ack_slot:
  assert property (busy_ff && (first_ff || !dir_ff) && bit_ff == 4'h8 && scl
    |-> m_sda_oe_n)
    else $error("master drove in slave acknowledge slot");
  chk_nack_release:
  assert property (nack_ff |-> s_sda_oe_n)
    else $error("slave drove after master refusal");
  chk_idle_release:
  assert property (!busy_ff |-> s_sda_oe_n)
    else $error("slave drove on idle bus");
  chk_ninth_clock:
  assert property ((start_c || stop_c) && busy_ff |-> bit_ff == 4'h0)
    else $error("condition inside a byte frame");
  chk_clock_framed:
  assert property (fall_c |-> busy_ff)
    else $error("clock pulse outside a transfer");
endmodule

// ==== test/two_wire_slave_port_tb.sv ====
// Bench joining master and slave port on one two-wire bus.
// Fast pair is watched by the checker; a second pair runs the regular rate.
`timescale 1ns/1ps
module two_wire_slave_port_tb;
  localparam int LIM = 20000;
  // Arbitrary value
  localparam logic [3:0] TC = 4'h6;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [7:0] main_addr = 8'hAC;
  logic rx_ready = 1'b0;
  logic [7:0] tx_q [4] = '{8'h81, 8'h42, 8'hC6, 8'h18};
  logic tx_valid = 1'b1;
  int tx_idx = 0;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd = 2'h0;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_nack = 1'b0;
  logic cmd_ready, rsp_valid, rsp_ack, rx_valid, tx_ready;
  logic sel_main, sel_aux, rd_mode;
  logic [7:0] rsp_data, rx_data;
  logic [8:0] wire_sr = 9'h000;
  logic scl_d = 1'b1;
  int num_errors = 0;
  int n_tests = 0;
  bit use_slow = 1'b0;
  logic cmd_valid_s = 1'b0;
  logic cmd_ready_s, rsp_valid_s, rsp_ack_s, rx_valid_s;
  logic [7:0] rx_data_s;

  twsp_if twsp_if_i ();
  twsp_dev #(.TYPE_CODE(TC)) twsp_dev_i (.clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in), .bus(twsp_if_i), .main_addr_in(main_addr),
    .rx_data_out(rx_data), .rx_valid_out(rx_valid), .rx_ready_in(rx_ready),
    .tx_data_in(tx_q[tx_idx[1:0]]), .tx_valid_in(tx_valid),
    .tx_ready_out(tx_ready), .sel_main_out(sel_main),
    .sel_aux_out(sel_aux), .rd_mode_out(rd_mode));
  twsp_host #(.SCL_HZ(twsp_pkg::SCL_FAST_HZ)) twsp_host_i (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .bus(twsp_if_i),
    .cmd_valid_in(cmd_valid), .cmd_in(cmd), .cmd_data_in(cmd_data),
    .cmd_nack_in(cmd_nack), .cmd_ready_out(cmd_ready),
    .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data),
    .rsp_ack_out(rsp_ack));
  twsp_checker twsp_checker_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .scl(twsp_if_i.scl), .sda(twsp_if_i.sda),
    .m_sda_oe_n(twsp_if_i.m_sda_oe_n), .s_sda_oe_n(twsp_if_i.s_sda_oe_n));
  // Second pair at the regular line rate
  twsp_if slow_if_i ();
  twsp_dev #(.TYPE_CODE(TC)) twsp_dev_slow_i (.clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in), .bus(slow_if_i), .main_addr_in(main_addr),
    .rx_data_out(rx_data_s), .rx_valid_out(rx_valid_s), .rx_ready_in(1'b0),
    .tx_data_in(8'h00), .tx_valid_in(1'b0), .tx_ready_out(),
    .sel_main_out(), .sel_aux_out(), .rd_mode_out());
  twsp_host #(.SCL_HZ(twsp_pkg::SCL_STD_HZ)) twsp_host_slow_i (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .bus(slow_if_i),
    .cmd_valid_in(cmd_valid_s), .cmd_in(cmd), .cmd_data_in(cmd_data),
    .cmd_nack_in(cmd_nack), .cmd_ready_out(cmd_ready_s),
    .rsp_valid_out(rsp_valid_s), .rsp_data_out(), .rsp_ack_out(rsp_ack_s));

  always #4 clk_sys_in = ~clk_sys_in;
  always @(negedge clk_sys_in) if (tx_ready === 1'b1) tx_idx <= tx_idx + 1;
  // Bits seen on the wire at each clock rise
  always @(posedge clk_sys_in) begin
    scl_d <= twsp_if_i.scl;
    if (twsp_if_i.scl && !scl_d) wire_sr <= {wire_sr[7:0], twsp_if_i.sda};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input bit ok, input string msg);
    n_tests++;
    if (!ok) begin
      num_errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic bus_cmd(input twsp_pkg::twsp_cmd_t c, input logic [7:0] d,
                         input logic nk);
    int n;
    n = 0;
    cmd = c;
    cmd_data = d;
    cmd_nack = nk;
    cmd_valid = !use_slow;
    cmd_valid_s = use_slow;
    while ((use_slow ? cmd_ready_s : cmd_ready) !== 1'b1 && n < LIM) begin
      @(negedge clk_sys_in);
      n++;
    end
    @(negedge clk_sys_in);
    cmd_valid = 1'b0;
    cmd_valid_s = 1'b0;
    while ((use_slow ? rsp_valid_s : rsp_valid) !== 1'b1 && n < LIM) begin
      @(negedge clk_sys_in);
      n++;
    end
    if (n >= LIM) begin
      chk(1'b0, "host command timeout");
      give_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] d, input logic ack);
    bus_cmd(twsp_pkg::CMD_WRITE, d, 1'b0);
    chk(rsp_ack === ack, "write acknowledge");
    chk(wire_sr === {d, ~ack}, "write byte on wire");
  endtask

  task automatic rd(input logic [7:0] d, input logic nk);
    bus_cmd(twsp_pkg::CMD_READ, 8'h00, nk);
    chk(rsp_data === d, "read data");
    chk(wire_sr === {d, nk}, "read byte on wire");
  endtask

  task automatic pop(input logic [7:0] d);
    int n;
    n = 0;
    while (rx_valid !== 1'b1 && n < LIM) begin
      @(negedge clk_sys_in);
      n++;
    end
    chk(rx_valid === 1'b1 && rx_data === d, "received byte");
    rx_ready = 1'b1;
    @(negedge clk_sys_in);
    rx_ready = 1'b0;
    @(negedge clk_sys_in);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_write_aux();
    chk(twsp_if_i.scl === 1'b1 && twsp_if_i.sda === 1'b1, "bus idle");
    bus_cmd(twsp_pkg::CMD_START, 8'h00, 1'b0);
    wr({TC, 3'b000, 1'b0}, 1'b1);
    chk(sel_aux === 1'b1 && sel_main === 1'b0, "aux selected");
    chk(rd_mode === 1'b0, "write direction");
    wr(8'h5A, 1'b1);
    wr(8'hC3, 1'b1);
    wr(8'h99, 1'b0);
    bus_cmd(twsp_pkg::CMD_STOP, 8'h00, 1'b0);
    pop(8'h5A);
    pop(8'hC3);
    @(negedge clk_sys_in);
    chk(rx_valid === 1'b0, "buffer drained");
    $display("test write_aux done");
  endtask

  task automatic t_main_read();
    bus_cmd(twsp_pkg::CMD_START, 8'h00, 1'b0);
    wr({TC, 3'b110, 1'b0}, 1'b1);
    wr(8'h7E, 1'b1);
    bus_cmd(twsp_pkg::CMD_START, 8'h00, 1'b0);
    wr({TC, 3'b110, 1'b1}, 1'b1);
    chk(sel_main === 1'b1 && sel_aux === 1'b0, "main selected");
    chk(rd_mode === 1'b1, "read direction");
    rd(8'h81, 1'b0);
    rd(8'h42, 1'b1);
    bus_cmd(twsp_pkg::CMD_STOP, 8'h00, 1'b0);
    chk(tx_idx == 2, "bytes taken for sending");
    pop(8'h7E);
    $display("test main_read done");
  endtask

  task automatic t_mismatch();
    bus_cmd(twsp_pkg::CMD_START, 8'h00, 1'b0);
    wr({4'h5, 3'b000, 1'b0}, 1'b0);
    bus_cmd(twsp_pkg::CMD_START, 8'h00, 1'b0);
    wr({TC, 3'b001, 1'b0}, 1'b0);
    wr(8'h3C, 1'b0);
    bus_cmd(twsp_pkg::CMD_START, 8'h00, 1'b0);
    wr({TC, 3'b000, 1'b1}, 1'b1);
    rd(8'hC6, 1'b0);
    tx_valid = 1'b0;
    rd(twsp_pkg::IDLE_BYTE, 1'b1);
    chk(tx_idx == 3, "idle byte not taken");
    bus_cmd(twsp_pkg::CMD_STOP, 8'h00, 1'b0);
    tx_valid = 1'b1;
    chk(rx_valid === 1'b0, "ignored byte not received");
    $display("test mismatch done");
  endtask

  task automatic t_slow_rate();
    use_slow = 1'b1;
    bus_cmd(twsp_pkg::CMD_START, 8'h00, 1'b0);
    bus_cmd(twsp_pkg::CMD_WRITE, {TC, 3'b000, 1'b0}, 1'b0);
    chk(rsp_ack_s === 1'b1, "slow control acknowledge");
    bus_cmd(twsp_pkg::CMD_WRITE, 8'h3D, 1'b0);
    chk(rsp_ack_s === 1'b1, "slow data acknowledge");
    bus_cmd(twsp_pkg::CMD_STOP, 8'h00, 1'b0);
    use_slow = 1'b0;
    chk(rx_valid_s === 1'b1 && rx_data_s === 8'h3D, "slow byte rx");
    $display("test slow_rate done");
  endtask

  initial begin
    repeat (2) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    rstn_in = 1'b1;
    @(negedge clk_sys_in);
    t_write_aux();
    t_main_read();
    t_mismatch();
    t_slow_rate();
    give_verdict();
  end
endmodule
